// ==== dv/tb_top.sv ====
// ==========================================================
// Self-checking bench for the ingress function gate bank.
// Assumes ifcs_defs.svh and ifcs_pkg are compiled ahead of it.
`timescale 1ns/1ps
`include "ifcs_defs.svh"

`define CHECK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top;
  // ==========================================================
  // Signals
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic pkt_valid;
  logic pkt_cpu_port;
  logic pkt_cpu_tag;
  logic pkt_keep_bit;
  logic pkt_decrypted;
  logic [36:0] gate_vec;
  logic gate_valid;
  ifcs_pkg::ifcs_class_t gate_class;
  logic pkt_drop;
  int bad_count;
  int checked;
  logic [36:0] v;

  // Reset gates worked out bit by bit from the field table
  localparam logic [36:0] DNM_RST = 37'h1F_FDFF_7761;
  localparam logic [36:0] DEC_RST = 37'h17_BFFF_FFF1;

  ifcs_gate_bank u_ifcs_gate_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_cpu_port(pkt_cpu_port),
    .pkt_cpu_tag(pkt_cpu_tag), .pkt_keep_bit(pkt_keep_bit), .pkt_decrypted(pkt_decrypted),
    .gate_vec(gate_vec), .gate_valid(gate_valid), .gate_class(gate_class), .pkt_drop(pkt_drop)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================
  // APB master; pready is sampled at the rising edge that closes the
  // access phase, and read data and error are taken at that same edge
  task automatic apb(input logic wr, input logic [29:0] idx, input logic [1:0] lo, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count of its own: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_wr(input logic [29:0] idx, input logic [1:0] lo, input logic [31:0] d,
                        input logic [3:0] st, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, lo, d, st, rd, err);
    `CHECK_EQ(err, experr)
  endtask : reg_wr

  task automatic reg_rd(input logic [29:0] idx, input logic [1:0] lo, input logic [31:0] exp,
                        input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, lo, 32'h0, 4'hF, rd, err);
    `CHECK_EQ(rd, exp)
    `CHECK_EQ(err, experr)
  endtask : reg_rd

  // ==========================================================
  // One packet descriptor; the answer stands for one cycle only
  task automatic pkt(input logic cp, input logic tg, input logic kp, input logic dc, input logic [36:0] ev,
                     input ifcs_pkg::ifcs_class_t ec, input logic ed);
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt_cpu_port <= cp;
    pkt_cpu_tag <= tg;
    pkt_keep_bit <= kp;
    pkt_decrypted <= dc;
    @(posedge pclk);
    pkt_valid <= 1'b0;
    @(negedge pclk);
    `CHECK_EQ(gate_valid, 1'b1)
    `CHECK_EQ(gate_vec, ev)
    `CHECK_EQ(gate_class, ec)
    `CHECK_EQ(pkt_drop, ed)
    @(negedge pclk);
    `CHECK_EQ(gate_valid, 1'b0)
  endtask : pkt

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Whole run is near 1000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end

  // ==========================================================
  // Tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {pkt_valid, pkt_cpu_port, pkt_cpu_tag, pkt_keep_bit, pkt_decrypted} = '0;
    presetn = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reg_rd(`IFCS_DEC_IDX, 2'b00, DEC_RST[31:0], 1'b0);
    reg_rd(`IFCS_DEC_HI_IDX, 2'b00, {27'h0, DEC_RST[36:32]}, 1'b0);
    reg_rd(`IFCS_DNM_IDX, 2'b00, DNM_RST[31:0], 1'b0);
    reg_rd(`IFCS_DNM_HI_IDX, 2'b00, {27'h0, DNM_RST[36:32]}, 1'b0);
    reg_rd(`IFCS_DROP_CNT_IDX, 2'b00, 32'h0, 1'b0);
    $display("test reset_values done");
    pkt(1'b1, 1'b1, 1'b1, 1'b0, DNM_RST, ifcs_pkg::IFCS_CLS_DNM, 1'b0);
    pkt(1'b1, 1'b1, 1'b0, 1'b0, 37'h0, ifcs_pkg::IFCS_CLS_NONE, 1'b0);
    pkt(1'b0, 1'b1, 1'b1, 1'b0, 37'h0, ifcs_pkg::IFCS_CLS_NONE, 1'b0);
    pkt(1'b1, 1'b0, 1'b1, 1'b0, 37'h0, ifcs_pkg::IFCS_CLS_NONE, 1'b0);
    pkt(1'b0, 1'b0, 1'b0, 1'b1, DEC_RST, ifcs_pkg::IFCS_CLS_DEC, 1'b0);
    $display("test class_select done");
    // Walking one in one gate, walking zero in the other; junk in unused high bits
    for (int i = 0; i < 37; i++) begin
      v = 37'h1 << i;
      reg_wr(`IFCS_DEC_IDX, 2'b00, v[31:0], 4'hF, 1'b0);
      reg_wr(`IFCS_DEC_HI_IDX, 2'b00, {27'h7FFFFFF, v[36:32]}, 4'hF, 1'b0);
      reg_wr(`IFCS_DNM_IDX, 2'b00, ~v[31:0], 4'hF, 1'b0);
      reg_wr(`IFCS_DNM_HI_IDX, 2'b00, {27'h7FFFFFF, ~v[36:32]}, 4'hF, 1'b0);
      reg_rd(`IFCS_DEC_HI_IDX, 2'b00, {27'h0, v[36:32]}, 1'b0);
      reg_rd(`IFCS_DNM_IDX, 2'b00, ~v[31:0], 1'b0);
      pkt(1'b0, 1'b0, 1'b0, 1'b1, v, ifcs_pkg::IFCS_CLS_DEC, (i == 2));
      pkt(1'b1, 1'b1, 1'b1, 1'b0, ~v, ifcs_pkg::IFCS_CLS_DNM, (i != 2));
    end
    // Gate bits 32 to 36 travel in the same walk
    $display("test bit_walk done");
    // One forced discard from the decrypted walk, 36 from the other
    reg_rd(`IFCS_DROP_CNT_IDX, 2'b00, 32'h25, 1'b0);
    reg_wr(`IFCS_DROP_CNT_IDX, 2'b00, 32'hFFFF_FFFF, 4'hF, 1'b0);
    reg_rd(`IFCS_DROP_CNT_IDX, 2'b00, 32'h25, 1'b0);
    $display("test drop_count done");
    reg_wr(`IFCS_DEC_IDX, 2'b10, 32'hFFFF_FFFF, 4'hF, 1'b1);
    reg_rd(`IFCS_DEC_IDX, 2'b00, 32'h0, 1'b0);
    reg_rd(`IFCS_DEC_IDX, 2'b01, 32'h0, 1'b1);
    reg_wr(30'h001120A7, 2'b00, 32'hFFFF_FFFF, 4'hF, 1'b1);
    reg_rd(30'h001120A7, 2'b00, 32'h0, 1'b1);
    reg_wr(`IFCS_DNM_IDX, 2'b00, 32'h0000_00AA, 4'h1, 1'b0);
    reg_rd(`IFCS_DNM_IDX, 2'b00, 32'hFFFF_FFAA, 1'b0);
    $display("test refusals done");
    // Second reset in mid-run brings back both defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    `CHECK_EQ(pready, 1'b0)
    `CHECK_EQ(gate_valid, 1'b0)
    `CHECK_EQ(gate_vec, 37'h0)
    @(posedge pclk);
    presetn <= 1'b1;
    reg_rd(`IFCS_DNM_IDX, 2'b00, DNM_RST[31:0], 1'b0);
    reg_rd(`IFCS_DROP_CNT_IDX, 2'b00, 32'h0, 1'b0);
    pkt(1'b0, 1'b0, 1'b0, 1'b1, DEC_RST, ifcs_pkg::IFCS_CLS_DEC, 1'b0);
    $display("test second_reset done");
    test_done();
  end
endmodule : tb_top

// ==== src/ifcs_defs.svh ====
// Register map, field positions and reset values of the ingress function gates.
// Assumes it is included by the package, the design and the bench, nothing else.
`ifndef IFCS_DEFS_SVH
`define IFCS_DEFS_SVH

// ==========================================================
// Register word indices; byte address is four times the index
`define IFCS_DEC_IDX 30'h001120A5
`define IFCS_DEC_HI_IDX 30'h001120A6
`define IFCS_DNM_IDX 30'h001120AF
`define IFCS_DNM_HI_IDX 30'h001120B0
`define IFCS_DROP_CNT_IDX 30'h001120B1

// ==========================================================
// Gate vector geometry
`define IFCS_GATE_W 37
`define IFCS_HI_W 5
`define IFCS_DNM_RST 37'h1F_FDFF_7761
`define IFCS_DEC_RST 37'h17_BFFF_FFF1

// ==========================================================
// Field positions inside a gate vector
`define IFCS_B_LOOKUP 0
`define IFCS_B_LEARN_INH 1
`define IFCS_B_DISCARD 2
`define IFCS_B_CPU_BYPASS 3
`define IFCS_B_ROUTE 4
`define IFCS_B_RSV_DMAC 5
`define IFCS_B_RSV_SMAC 6
`define IFCS_B_PORT_VLAN 7
`define IFCS_B_TUNNEL 8
`define IFCS_B_MON_CNT 9
`define IFCS_B_IN_PFILT 10
`define IFCS_B_IN_ACL 11
`define IFCS_B_IN_STP 12
`define IFCS_B_OUT_STP 13
`define IFCS_B_VLAN_DROP 14
`define IFCS_B_VID_OP 15
`define IFCS_B_IN_MSTP 16
`define IFCS_B_OUT_MSTP 17
`define IFCS_B_CSUM 18
`define IFCS_B_L2_ACT 19
`define IFCS_B_MOVE 20
`define IFCS_B_POLICER 21
`define IFCS_B_VRF 22
`define IFCS_B_NH_HIT 23
`define IFCS_B_NH_VLAN 24
`define IFCS_B_OUT_ACL 25
`define IFCS_B_IN_NAT 26
`define IFCS_B_OUT_NAT 27
`define IFCS_B_NAT_ACT 28
`define IFCS_B_STORM 29
`define IFCS_B_IN_MIRROR 30
`define IFCS_B_QUEUE_ON 31
`define IFCS_B_RX_STAT 32
`define IFCS_B_REUSE_PM 33
`define IFCS_B_REUSE_Q 34
`define IFCS_B_CIPH_MIR_OFF 35
`define IFCS_B_XPORT_FILT 36

`endif

// ==== src/ifcs_gate_bank.sv ====
// Ingress function gate bank: two per-class gate registers behind APB,
// selected per packet and handed to the ingress pipeline stages.
// Assumes packet descriptors are synchronous to pclk and valid for one cycle.
`timescale 1ns/1ps
`include "ifcs_defs.svh"

module ifcs_gate_bank #(
  parameter int DROP_CNT_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Packet descriptor from the ingress stage
  input wire logic pkt_valid,
  input wire logic pkt_cpu_port,
  input wire logic pkt_cpu_tag,
  input wire logic pkt_keep_bit,
  input wire logic pkt_decrypted,
  // Selected gate toward the pipeline stages
  output logic [`IFCS_GATE_W-1:0] gate_vec,
  output logic gate_valid,
  output ifcs_pkg::ifcs_class_t gate_class,
  output logic pkt_drop
);

  // ==========================================================
  // Helpers
  function automatic ifcs_pkg::ifcs_sel_t decode_addr(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    decode_addr = ifcs_pkg::IFCS_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (idx)
        `IFCS_DEC_IDX: decode_addr = ifcs_pkg::IFCS_SEL_DEC_LO;
        `IFCS_DEC_HI_IDX: decode_addr = ifcs_pkg::IFCS_SEL_DEC_HI;
        `IFCS_DNM_IDX: decode_addr = ifcs_pkg::IFCS_SEL_DNM_LO;
        `IFCS_DNM_HI_IDX: decode_addr = ifcs_pkg::IFCS_SEL_DNM_HI;
        `IFCS_DROP_CNT_IDX: decode_addr = ifcs_pkg::IFCS_SEL_DROP;
        default: decode_addr = ifcs_pkg::IFCS_SEL_NONE;
      endcase
    end
  endfunction : decode_addr

  // Byte lanes not strobed keep their old contents
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    merge_lanes = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_lanes[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction : merge_lanes

  // ==========================================================
  // State
  ifcs_pkg::ifcs_state_t s_q;
  ifcs_pkg::ifcs_state_t s_d;
  ifcs_pkg::ifcs_sel_t sel_setup;
  ifcs_pkg::ifcs_sel_t sel_access;
  logic setup_phase;
  logic write_take;
  logic [`IFCS_GATE_W-1:0] src_gate;
  ifcs_pkg::ifcs_class_t pkt_class;
  logic is_dnm;
  logic is_dec;

  assign setup_phase = psel && !penable;
  assign sel_setup = decode_addr(paddr);
  assign sel_access = decode_addr(paddr);
  // Writes land only on the edge where the access phase completes
  assign write_take = psel && penable && s_q.pready && pwrite;

  assign is_dnm = pkt_cpu_port && pkt_cpu_tag && pkt_keep_bit;
  assign is_dec = pkt_decrypted;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;

    // APB: answer is registered, so pready rises in the first access cycle
    if (setup_phase) begin
      s_d.pready = 1'b1;
      s_d.pslverr = (sel_setup == ifcs_pkg::IFCS_SEL_NONE);
      if (!pwrite) begin
        unique case (sel_setup)
          ifcs_pkg::IFCS_SEL_DEC_LO: s_d.prdata = s_q.dec[31:0];
          ifcs_pkg::IFCS_SEL_DEC_HI: s_d.prdata = {27'h0, s_q.dec[36:32]};
          ifcs_pkg::IFCS_SEL_DNM_LO: s_d.prdata = s_q.dnm[31:0];
          ifcs_pkg::IFCS_SEL_DNM_HI: s_d.prdata = {27'h0, s_q.dnm[36:32]};
          ifcs_pkg::IFCS_SEL_DROP: s_d.prdata = 32'(s_q.drop_cnt);
          ifcs_pkg::IFCS_SEL_NONE: s_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes; the drop counter is read-only
    if (write_take) begin
      unique case (sel_access)
        ifcs_pkg::IFCS_SEL_DEC_LO: s_d.dec[31:0] = merge_lanes(s_q.dec[31:0], pwdata, pstrb);
        ifcs_pkg::IFCS_SEL_DEC_HI: begin
          if (pstrb[0]) begin
            s_d.dec[36:32] = pwdata[`IFCS_HI_W-1:0];
          end
        end
        ifcs_pkg::IFCS_SEL_DNM_LO: s_d.dnm[31:0] = merge_lanes(s_q.dnm[31:0], pwdata, pstrb);
        ifcs_pkg::IFCS_SEL_DNM_HI: begin
          if (pstrb[0]) begin
            s_d.dnm[36:32] = pwdata[`IFCS_HI_W-1:0];
          end
        end
        ifcs_pkg::IFCS_SEL_DROP: s_d.drop_cnt = s_q.drop_cnt;
        ifcs_pkg::IFCS_SEL_NONE: s_d.drop_cnt = s_q.drop_cnt;
      endcase
    end

    // Per-packet class select. A decrypted packet comes back from the
    // crypto engine, never from the CPU port, so it takes priority.
    if (is_dec) begin
      pkt_class = ifcs_pkg::IFCS_CLS_DEC;
      src_gate = s_q.dec;
    end else if (is_dnm) begin
      pkt_class = ifcs_pkg::IFCS_CLS_DNM;
      src_gate = s_q.dnm;
    end else begin
      // Other classes are served by sibling gate banks
      pkt_class = ifcs_pkg::IFCS_CLS_NONE;
      src_gate = '0;
    end

    // Gate fields handed to the pipeline, grouped by the stage that reads them
    s_d.gate_valid = pkt_valid;
    s_d.gate_class = pkt_valid ? pkt_class : ifcs_pkg::IFCS_CLS_NONE;
    s_d.gate = '0;
    if (pkt_valid) begin
      s_d.gate[`IFCS_B_LOOKUP] = src_gate[`IFCS_B_LOOKUP];
      s_d.gate[`IFCS_B_LEARN_INH] = src_gate[`IFCS_B_LEARN_INH];
      s_d.gate[`IFCS_B_DISCARD] = src_gate[`IFCS_B_DISCARD];
      s_d.gate[`IFCS_B_CPU_BYPASS] = src_gate[`IFCS_B_CPU_BYPASS];
      s_d.gate[`IFCS_B_ROUTE] = src_gate[`IFCS_B_ROUTE];
      s_d.gate[`IFCS_B_RSV_SMAC:`IFCS_B_RSV_DMAC] = src_gate[`IFCS_B_RSV_SMAC:`IFCS_B_RSV_DMAC];
      s_d.gate[`IFCS_B_PORT_VLAN] = src_gate[`IFCS_B_PORT_VLAN];
      s_d.gate[`IFCS_B_VID_OP] = src_gate[`IFCS_B_VID_OP];
      s_d.gate[`IFCS_B_IN_PFILT:`IFCS_B_TUNNEL] = src_gate[`IFCS_B_IN_PFILT:`IFCS_B_TUNNEL];
      s_d.gate[`IFCS_B_IN_ACL] = src_gate[`IFCS_B_IN_ACL];
      s_d.gate[`IFCS_B_OUT_ACL] = src_gate[`IFCS_B_OUT_ACL];
      s_d.gate[`IFCS_B_OUT_STP:`IFCS_B_IN_STP] = src_gate[`IFCS_B_OUT_STP:`IFCS_B_IN_STP];
      s_d.gate[`IFCS_B_OUT_MSTP:`IFCS_B_IN_MSTP] = src_gate[`IFCS_B_OUT_MSTP:`IFCS_B_IN_MSTP];
      s_d.gate[`IFCS_B_VLAN_DROP] = src_gate[`IFCS_B_VLAN_DROP];
      s_d.gate[`IFCS_B_L2_ACT:`IFCS_B_CSUM] = src_gate[`IFCS_B_L2_ACT:`IFCS_B_CSUM];
      s_d.gate[`IFCS_B_MOVE] = src_gate[`IFCS_B_MOVE];
      s_d.gate[`IFCS_B_NH_HIT:`IFCS_B_POLICER] = src_gate[`IFCS_B_NH_HIT:`IFCS_B_POLICER];
      s_d.gate[`IFCS_B_NH_VLAN] = src_gate[`IFCS_B_NH_VLAN];
      s_d.gate[`IFCS_B_NAT_ACT:`IFCS_B_IN_NAT] = src_gate[`IFCS_B_NAT_ACT:`IFCS_B_IN_NAT];
      s_d.gate[`IFCS_B_RX_STAT:`IFCS_B_STORM] = src_gate[`IFCS_B_RX_STAT:`IFCS_B_STORM];
      s_d.gate[`IFCS_B_REUSE_Q:`IFCS_B_REUSE_PM] = src_gate[`IFCS_B_REUSE_Q:`IFCS_B_REUSE_PM];
      s_d.gate[`IFCS_B_XPORT_FILT:`IFCS_B_CIPH_MIR_OFF] =
        src_gate[`IFCS_B_XPORT_FILT:`IFCS_B_CIPH_MIR_OFF];
    end

    // Forced discard is counted where the decision is made; wraps at the top
    s_d.pkt_drop = pkt_valid && src_gate[`IFCS_B_DISCARD];
    if (s_d.pkt_drop) begin
      s_d.drop_cnt = s_q.drop_cnt + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.dnm <= `IFCS_DNM_RST;
      s_q.dec <= `IFCS_DEC_RST;
      s_q.drop_cnt <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
      s_q.gate <= '0;
      s_q.gate_valid <= 1'b0;
      s_q.gate_class <= ifcs_pkg::IFCS_CLS_NONE;
      s_q.pkt_drop <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign gate_vec = s_q.gate;
  assign gate_valid = s_q.gate_valid;
  assign gate_class = s_q.gate_class;
  assign pkt_drop = s_q.pkt_drop;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dnm_select;
    pkt_valid && is_dnm && !is_dec |=> gate_valid && gate_class == ifcs_pkg::IFCS_CLS_DNM
      && gate_vec == $past(s_q.dnm);
  endproperty
  a_dnm_select: assert property (p_dnm_select) else $error("do-not-modify gate not selected");

  property p_dec_select;
    pkt_valid && is_dec |=> gate_class == ifcs_pkg::IFCS_CLS_DEC && gate_vec == $past(s_q.dec);
  endproperty
  a_dec_select: assert property (p_dec_select) else $error("decrypted gate not selected");

  property p_lo_write;
    psel && penable && pready && pwrite && pstrb == 4'hF
      && paddr == {`IFCS_DNM_IDX, 2'b00} |=> s_q.dnm[31:0] == $past(pwdata);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low word write lost");

  property p_hi_read;
    psel && penable && pready && !pwrite && paddr == {`IFCS_DEC_HI_IDX, 2'b00}
      |-> prdata == {27'h0, s_q.dec[36:32]};
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high word read wrong");

  property p_drop_count;
    pkt_drop |-> s_q.drop_cnt == $past(s_q.drop_cnt) + 32'h0000_0001;
  endproperty
  a_drop_count: assert property (p_drop_count) else $error("drop not counted");

  property p_drop_cause;
    pkt_drop |-> gate_valid && gate_vec[`IFCS_B_DISCARD];
  endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop without discard bit");

  property p_no_class;
    pkt_valid && !is_dnm && !is_dec |=> gate_valid && gate_vec == '0
      && gate_class == ifcs_pkg::IFCS_CLS_NONE;
  endproperty
  a_no_class: assert property (p_no_class) else $error("foreign packet got a gate");

  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready timing wrong");

  property p_unmapped;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");

  property p_lookup_bit;
    pkt_valid && is_dec |=> gate_vec[`IFCS_B_LOOKUP] == $past(s_q.dec[`IFCS_B_LOOKUP])
      && gate_vec[`IFCS_B_ROUTE] == $past(s_q.dec[`IFCS_B_ROUTE]);
  endproperty
  a_lookup_bit: assert property (p_lookup_bit) else $error("lookup or route bit mismatch");

endmodule : ifcs_gate_bank

// ==== src/ifcs_pkg.sv ====
// Types shared by the ingress function gate bank.
// Assumes ifcs_defs.svh is on the include path.
package ifcs_pkg;
  `include "ifcs_defs.svh"

  // ==========================================================
  // Packet class that picked a gate vector
  typedef enum logic [1:0] {
    IFCS_CLS_NONE,
    IFCS_CLS_DNM,
    IFCS_CLS_DEC
  } ifcs_class_t;

  // ==========================================================
  // Register selected by an APB address
  typedef enum logic [2:0] {
    IFCS_SEL_NONE,
    IFCS_SEL_DEC_LO,
    IFCS_SEL_DEC_HI,
    IFCS_SEL_DNM_LO,
    IFCS_SEL_DNM_HI,
    IFCS_SEL_DROP
  } ifcs_sel_t;

  // ==========================================================
  // Whole module state
  typedef struct packed {
    logic [`IFCS_GATE_W-1:0] dnm;
    logic [`IFCS_GATE_W-1:0] dec;
    logic [31:0] drop_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`IFCS_GATE_W-1:0] gate;
    logic gate_valid;
    ifcs_class_t gate_class;
    logic pkt_drop;
  } ifcs_state_t;
endpackage : ifcs_pkg
